// ===== common/spi_eeprom_pkg.sv
/*
  Shared constants and types for the serial EEPROM command front end.
  Assumes a 125 MHz system clock and a host-driven serial clock.
*/
package spi_eeprom_pkg;

  localparam logic [7:0] OPC_ENABLE_WRITE = 8'h06;
  localparam logic [7:0] OPC_DISABLE_WRITE = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_LOAD_STATUS = 8'h01;
  localparam logic [7:0] OPC_READ_MEM = 8'h03;
  localparam logic [7:0] OPC_WRITE_MEM = 8'h02;

  // Status register bit positions.
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_PROT_LO = 2;
  localparam int SR_PROT_HI = 3;
  localparam int SR_LOCK = 4;
  localparam int SR_PAGE_SEL = 6;
  localparam int SR_GUARD_EN = 7;
  localparam logic [7:0] SR_LOAD_MASK = 8'hDC;
  localparam logic [7:0] SR_RESET = 8'h00;

  localparam int ADDR_BITS = 16;
  localparam int PAGE_BYTES = 32;
  localparam int ARRAY_ADDR_W = 13;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h0F;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // Timing, as times and as system clock counts (longest times round down).
  localparam int SYS_CLK_NS = 8;
  localparam int WRITE_CYCLE_NS = 4_000_000;
  localparam int POWER_UP_NS = 350_000;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / SYS_CLK_NS;
  localparam int POWER_UP_CYCLES = POWER_UP_NS / SYS_CLK_NS;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SET_WEL = 3'h1,
    OP_CLR_WEL = 3'h2,
    OP_LOAD_STATUS = 3'h3,
    OP_WRITE = 3'h4,
    OP_READ = 3'h5
  } frame_op_e;

  typedef enum logic [6:0] {
    LS_OPCODE = 7'b000_0001,
    LS_ADDR = 7'b000_0010,
    LS_DATA_IN = 7'b000_0100,
    LS_DATA_OUT = 7'b000_1000,
    LS_STAT_IN = 7'b001_0000,
    LS_STAT_OUT = 7'b010_0000,
    LS_IGNORE = 7'b100_0000
  } link_state_e;

  // What a finished selection leaves for the system clock side.
  typedef struct packed {
    frame_op_e op;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0] status_data;
    logic [PAGE_BYTES-1:0] byte_mask;
    logic id_page;
  } frame_s;

endpackage

// ===== hdl/cycle_timer.sv
/*
  Down counter that stays running for COUNT cycles after a start pulse.
  Assumes start pulses that arrive while running may be dropped.
*/
`timescale 1ns/100ps
module cycle_timer #(
  parameter int COUNT = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  output logic o_running
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt_q;

  // Restart is ignored while running, so a cycle can never be shortened.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
    end else if (i_start && cnt_q == '0) begin
      cnt_q <= CW'(COUNT);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_running = (cnt_q != '0);
endmodule

// ===== hdl/spi_eeprom_command_front_end.sv
/*
  Serial EEPROM command front end: serial clock side decodes opcodes and
  streams data; system clock side owns status, write cycle and arrays.
  Assumes the serial clock stops between selections and the host keeps
  select high for a few system clocks between selections.
*/
`timescale 1ns/100ps
module spi_eeprom_command_front_end #(
  parameter int ARRAY_W = spi_eeprom_pkg::ARRAY_ADDR_W,
  parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_CYCLES,
  parameter int POWER_UP_CYCLES = spi_eeprom_pkg::POWER_UP_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe_n,
  output logic o_busy,
  output logic [7:0] o_status,
  output logic o_powerup_done
);
  localparam int PB = spi_eeprom_pkg::PAGE_BYTES;

  ////////////////////////////////////////////////////////////////////////////
  // Storage shared by both domains.

  // Main and ID arrays are written only on the system side while busy; the serial side
  // reads them only when not busy, so a read never sees a moving word.
  logic [7:0] main_mem [2**ARRAY_W];
  logic [7:0] id_mem [PB];
  logic [7:0] page_buf [PB];

  logic [7:0] status_q;
  logic [7:0] status_s;
  logic wc_running;
  spi_eeprom_pkg::frame_s frame_q;

  function automatic logic [7:0] read_byte(input logic [15:0] a, input logic id);
    if (id) begin
      read_byte = id_mem[a[4:0]];
    end else begin
      read_byte = main_mem[a[ARRAY_W-1:0]];
    end
  endfunction

  function automatic logic [15:0] next_addr(input logic [15:0] a, input logic id);
    if (id) begin
      next_addr = {a[15:5], a[4:0] + 5'h01};
    end else begin
      next_addr = a + 16'h0001;
    end
  endfunction

  function automatic logic prot_hit(input logic [15:0] a, input logic [1:0] bp);
    case (bp)
      2'b01: prot_hit = (a[ARRAY_W-1 -: 2] == 2'b11);
      2'b10: prot_hit = a[ARRAY_W-1];
      2'b11: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain.

  // Raising select clears the per-selection state at once, so nothing
  // depends on serial clock edges after the last one.
  logic link_rst_n;
  assign link_rst_n = i_resetn & ~i_cs_n;

  spi_eeprom_pkg::link_state_e state_q;
  logic [4:0] cnt_q;
  logic [7:0] shift_q;
  logic [15:0] addr_q;
  logic [7:0] tx_q;
  logic [4:0] wr_idx_q;
  logic out_en_q;
  logic started_q;
  logic is_read_q;
  logic so_q;
  logic [7:0] rx;
  logic [15:0] full_addr;
  logic byte_end;

  // Status is copied across as slow levels; the opcode is decoded eight
  // edges into the selection, well after this copy has settled.
  sync_two_flop #(.WIDTH(8), .RESET_VALUE(spi_eeprom_pkg::SR_RESET)) u_status_sync (
    .i_clk(i_sck),
    .i_resetn(i_resetn),
    .i_async(status_q),
    .o_sync(status_s)
  );

  assign rx = {shift_q[6:0], i_si};
  assign full_addr = {addr_q[14:0], i_si};
  assign byte_end = (cnt_q[2:0] == spi_eeprom_pkg::BYTE_LAST_BIT);

  // Main sequencer; a low pause pin freezes every register here.
  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_q <= spi_eeprom_pkg::LS_OPCODE;
      cnt_q <= '0;
      shift_q <= '0;
      addr_q <= '0;
      tx_q <= '0;
      wr_idx_q <= '0;
      out_en_q <= 1'b0;
      is_read_q <= 1'b0;
    end else if (i_hold_n) begin
      shift_q <= rx;
      cnt_q <= cnt_q + 5'h01;
      case (state_q)
        spi_eeprom_pkg::LS_OPCODE: begin
          if (byte_end) begin
            cnt_q <= '0;
            if (status_s[spi_eeprom_pkg::SR_BUSY] && rx != spi_eeprom_pkg::OPC_READ_STATUS) begin
              state_q <= spi_eeprom_pkg::LS_IGNORE;
            end else begin
              case (rx)
                spi_eeprom_pkg::OPC_READ_STATUS: begin
                  state_q <= spi_eeprom_pkg::LS_STAT_OUT;
                  tx_q <= status_s;
                  out_en_q <= 1'b1;
                end
                spi_eeprom_pkg::OPC_LOAD_STATUS: state_q <= spi_eeprom_pkg::LS_STAT_IN;
                spi_eeprom_pkg::OPC_READ_MEM: begin
                  state_q <= spi_eeprom_pkg::LS_ADDR;
                  is_read_q <= 1'b1;
                end
                spi_eeprom_pkg::OPC_WRITE_MEM: state_q <= spi_eeprom_pkg::LS_ADDR;
                default: state_q <= spi_eeprom_pkg::LS_IGNORE;
              endcase
            end
          end
        end
        spi_eeprom_pkg::LS_ADDR: begin
          addr_q <= full_addr;
          if (cnt_q == spi_eeprom_pkg::ADDR_LAST_BIT) begin
            cnt_q <= '0;
            wr_idx_q <= full_addr[4:0];
            if (is_read_q) begin
              state_q <= spi_eeprom_pkg::LS_DATA_OUT;
              tx_q <= read_byte(full_addr, status_s[spi_eeprom_pkg::SR_PAGE_SEL]);
              out_en_q <= 1'b1;
            end else begin
              state_q <= spi_eeprom_pkg::LS_DATA_IN;
            end
          end
        end
        spi_eeprom_pkg::LS_DATA_IN: begin
          if (byte_end) begin
            cnt_q <= '0;
            wr_idx_q <= wr_idx_q + 5'h01; // Rolls over inside the page.
          end
        end
        spi_eeprom_pkg::LS_DATA_OUT: begin
          if (byte_end) begin
            cnt_q <= '0;
            addr_q <= next_addr(addr_q, status_s[spi_eeprom_pkg::SR_PAGE_SEL]);
            tx_q <= read_byte(next_addr(addr_q, status_s[spi_eeprom_pkg::SR_PAGE_SEL]),
                              status_s[spi_eeprom_pkg::SR_PAGE_SEL]);
          end
        end
        spi_eeprom_pkg::LS_STAT_IN: begin
          if (byte_end) begin
            state_q <= spi_eeprom_pkg::LS_IGNORE;
          end
        end
        spi_eeprom_pkg::LS_STAT_OUT: begin
          if (byte_end) begin
            cnt_q <= '0;
            tx_q <= status_s; // Repeats with fresh busy state.
          end
        end
        spi_eeprom_pkg::LS_IGNORE: cnt_q <= '0;
        default: state_q <= spi_eeprom_pkg::LS_IGNORE;
      endcase
    end
  end

  // Marks the first edge of a selection so the result record can be cleared.
  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // Selection result and page buffer survive select rising; the system side
  // reads them after seeing select high, when no serial edge can arrive.
  always_ff @(posedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_q <= '0;
    end else if (!started_q) begin
      frame_q.op <= spi_eeprom_pkg::OP_NONE;
      frame_q.byte_mask <= '0;
    end else if (i_hold_n) begin
      case (state_q)
        spi_eeprom_pkg::LS_OPCODE: begin
          if (byte_end && !status_s[spi_eeprom_pkg::SR_BUSY]) begin
            frame_q.id_page <= status_s[spi_eeprom_pkg::SR_PAGE_SEL];
            if (rx == spi_eeprom_pkg::OPC_ENABLE_WRITE) begin
              frame_q.op <= spi_eeprom_pkg::OP_SET_WEL;
            end else if (rx == spi_eeprom_pkg::OPC_DISABLE_WRITE) begin
              frame_q.op <= spi_eeprom_pkg::OP_CLR_WEL;
            end else if (rx == spi_eeprom_pkg::OPC_READ_MEM) begin
              frame_q.op <= spi_eeprom_pkg::OP_READ;
            end
          end
        end
        spi_eeprom_pkg::LS_ADDR: frame_q.addr <= full_addr;
        spi_eeprom_pkg::LS_DATA_IN: begin
          if (byte_end) begin
            frame_q.op <= spi_eeprom_pkg::OP_WRITE;
            frame_q.byte_mask[wr_idx_q] <= 1'b1;
          end
        end
        spi_eeprom_pkg::LS_STAT_IN: begin
          if (byte_end) begin
            frame_q.op <= spi_eeprom_pkg::OP_LOAD_STATUS;
            frame_q.status_data <= rx;
          end
        end
        default: frame_q.op <= frame_q.op;
      endcase
    end
  end

  // Page buffer fill; only whole bytes are kept.
  always_ff @(posedge i_sck) begin
    if (!i_cs_n && i_hold_n && state_q == spi_eeprom_pkg::LS_DATA_IN && byte_end) begin
      page_buf[wr_idx_q] <= rx;
    end
  end

  // Output bit moves on the falling edge, ahead of the host's rising edge.
  always_ff @(negedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_q <= 1'b0;
    end else if (i_hold_n) begin
      so_q <= tx_q[3'h7 - cnt_q[2:0]];
    end
  end

  // Released while deselected, paused or not sending.
  assign o_so = so_q;
  assign o_so_oe_n = ~(out_en_q & ~i_cs_n & i_hold_n);

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain.

  logic cs_s;
  logic wp_s;
  logic cs_prev_q;
  logic cs_rise;
  logic wc_prev_q;
  logic start_wc;
  logic pu_started_q;
  logic pu_running;
  logic prog_q;
  logic [5:0] prog_idx_q;
  logic [PB-1:0] prog_mask_q;
  logic [15:0] prog_base_q;
  logic prog_id_q;
  logic guard_active;
  logic status_ok;
  logic mem_ok;
  logic [7:0] sr_new;

  sync_two_flop #(.WIDTH(2), .RESET_VALUE(2'b11)) u_pin_sync (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async({i_cs_n, i_wp_n}),
    .o_sync({cs_s, wp_s})
  );

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_prev_q <= 1'b1;
      wc_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      wc_prev_q <= wc_running;
    end
  end

  assign cs_rise = cs_s & ~cs_prev_q;

  // Hardware guard only when the pin is low and guard enable is one.
  assign guard_active = status_q[spi_eeprom_pkg::SR_GUARD_EN] & ~wp_s;
  assign status_ok = status_q[spi_eeprom_pkg::SR_WEL] & ~guard_active;
  // Protected ranges are larger than a page, so the page address decides.
  assign mem_ok = status_q[spi_eeprom_pkg::SR_WEL] & (frame_q.byte_mask != '0)
                & (frame_q.id_page
                   ? (~status_q[spi_eeprom_pkg::SR_LOCK]
                      & (status_q[3:2] != 2'b11)
                      & ~prot_hit({11'h000, frame_q.addr[4:0]}, status_q[3:2]))
                   : ~prot_hit(frame_q.addr, status_q[3:2]));

  // Page select and lock may not both be raised by one load.
  always_comb begin
    sr_new = (status_q & ~spi_eeprom_pkg::SR_LOAD_MASK)
           | (frame_q.status_data & spi_eeprom_pkg::SR_LOAD_MASK);
    if (frame_q.status_data[spi_eeprom_pkg::SR_PAGE_SEL] && frame_q.status_data[spi_eeprom_pkg::SR_LOCK]) begin
      sr_new[spi_eeprom_pkg::SR_PAGE_SEL] = status_q[spi_eeprom_pkg::SR_PAGE_SEL];
      sr_new[spi_eeprom_pkg::SR_LOCK] = status_q[spi_eeprom_pkg::SR_LOCK];
    end
    sr_new[spi_eeprom_pkg::SR_LOCK] = sr_new[spi_eeprom_pkg::SR_LOCK] | status_q[spi_eeprom_pkg::SR_LOCK];
  end

  assign start_wc = cs_rise & ~wc_running
                  & ((frame_q.op == spi_eeprom_pkg::OP_LOAD_STATUS & status_ok)
                     | (frame_q.op == spi_eeprom_pkg::OP_WRITE & mem_ok));

  // Commands take effect only once select has risen.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= spi_eeprom_pkg::SR_RESET;
    end else begin
      status_q[spi_eeprom_pkg::SR_BUSY] <= wc_running | start_wc;
      if (wc_prev_q && !wc_running) begin
        status_q[spi_eeprom_pkg::SR_WEL] <= 1'b0;
      end else if (cs_rise && !wc_running) begin
        case (frame_q.op)
          spi_eeprom_pkg::OP_SET_WEL: status_q[spi_eeprom_pkg::SR_WEL] <= 1'b1;
          spi_eeprom_pkg::OP_CLR_WEL: status_q[spi_eeprom_pkg::SR_WEL] <= 1'b0;
          spi_eeprom_pkg::OP_LOAD_STATUS: begin
            if (status_ok) begin
              status_q[7:2] <= sr_new[7:2];
            end
          end
          spi_eeprom_pkg::OP_WRITE, spi_eeprom_pkg::OP_READ: begin
            status_q[spi_eeprom_pkg::SR_PAGE_SEL] <= 1'b0;
          end
          default: status_q[spi_eeprom_pkg::SR_WEL] <= status_q[spi_eeprom_pkg::SR_WEL];
        endcase
      end
    end
  end

  // Programming walks the page once at the start of the timed cycle.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prog_q <= 1'b0;
      prog_idx_q <= '0;
      prog_mask_q <= '0;
      prog_base_q <= '0;
      prog_id_q <= 1'b0;
    end else if (start_wc && frame_q.op == spi_eeprom_pkg::OP_WRITE) begin
      prog_q <= 1'b1;
      prog_idx_q <= '0;
      prog_mask_q <= frame_q.byte_mask;
      prog_base_q <= frame_q.addr;
      prog_id_q <= frame_q.id_page;
    end else if (prog_q) begin
      prog_idx_q <= prog_idx_q + 6'h01;
      prog_q <= (prog_idx_q != 6'(PB - 1));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (prog_q && prog_mask_q[prog_idx_q[4:0]]) begin
      if (prog_id_q) begin
        id_mem[prog_idx_q[4:0]] <= page_buf[prog_idx_q[4:0]];
      end else begin
        main_mem[{prog_base_q[ARRAY_W-1:5], prog_idx_q[4:0]}] <= page_buf[prog_idx_q[4:0]];
      end
    end
  end

  // Timed write cycle runs on regardless of select. The busy bit trails the
  // timer by one cycle, so the timer runs one short to keep busy at exactly
  // WRITE_CYCLES cycles.
  cycle_timer #(.COUNT(WRITE_CYCLES - 1)) u_write_timer (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_start(start_wc),
    .o_running(wc_running)
  );

  // Power-up delay starts at the first edge after reset is released.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pu_started_q <= 1'b0;
    end else begin
      pu_started_q <= 1'b1;
    end
  end

  cycle_timer #(.COUNT(POWER_UP_CYCLES)) u_power_timer (
    .i_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_start(~pu_started_q),
    .o_running(pu_running)
  );

  assign o_powerup_done = pu_started_q & ~pu_running;
  assign o_busy = status_q[spi_eeprom_pkg::SR_BUSY];
  assign o_status = status_q;
endmodule

// ===== hdl/sync_two_flop.sv
/*
  Two flip-flop level synchroniser, any width.
  Assumes each bit is a slowly changing level, not a word.
*/
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= RESET_VALUE;
      o_sync <= RESET_VALUE;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ===== test/spi_eeprom_command_front_end_asserts.sv
/*
  Port checker for the serial EEPROM front end.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module spi_eeprom_command_front_end_asserts #(
  parameter int WRITE_CYCLES = 64,
  parameter int POWER_UP_CYCLES = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic o_so,
  input wire logic o_so_oe_n,
  input wire logic o_busy,
  input wire logic [7:0] o_status,
  input wire logic o_powerup_done
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic [31:0] busy_q;
  logic [31:0] up_q;
  ////////////////////////////////////////////////////////////////
  // Busy run length and time since reset; the time since reset saturates so a long run cannot wrap it.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= '0;
      up_q <= '0;
    end else begin
      busy_q <= o_busy ? busy_q + 1 : '0;
      up_q <= (up_q < 32'h0001_0000) ? up_q + 1 : up_q;
    end
  end
  // A latch may only rise once the host has let go; the guard is active while the pin is low and guard enable is one.
  sequence idle_s;
    i_cs_n && !o_busy;
  endsequence
  sequence guard_s;
    !i_wp_n && o_status[7];
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_OE_DESELECT: assert property (i_cs_n |-> o_so_oe_n) else $error("output driven while deselected");
  AST_OE_PAUSE: assert property (!i_hold_n |-> o_so_oe_n) else $error("output driven while paused");
  AST_SO_FALL: assert property (i_sck && $past(i_sck) |-> $stable(o_so)) else $error("output moved on high clock");
  AST_ZERO_BIT: assert property (o_status[5] == 1'b0) else $error("status bit five set");
  AST_BUSY_BIT: assert property (o_busy == o_status[0]) else $error("busy and status differ");
  AST_WEL_RISE: assert property ($rose(o_status[1]) |-> idle_s) else $error("latch set while selected");
  AST_WEL_END: assert property ($fell(o_busy) |-> !o_status[1]) else $error("latch kept after write");
  AST_BUSY_LEN: assert property (busy_q <= WRITE_CYCLES) else $error("write cycle too long");
  AST_GUARD: assert property (guard_s [*4] |=> $stable({o_status[7], o_status[4:2]})) else $error("guarded change");
  AST_POWER: assert property ($rose(o_powerup_done) |-> up_q >= POWER_UP_CYCLES) else $error("power up early");
endmodule

bind spi_eeprom_command_front_end spi_eeprom_command_front_end_asserts #(
  .WRITE_CYCLES(WRITE_CYCLES), .POWER_UP_CYCLES(POWER_UP_CYCLES)
) u_chk (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
  .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n), .o_busy(o_busy),
  .o_status(o_status), .o_powerup_done(o_powerup_done)
);

// ===== test/spi_eeprom_command_front_end_test.sv
/*
  Self-checking bench for the serial EEPROM front end.
  Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
module spi_eeprom_command_front_end_test;
  localparam int WC = 1000;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wp_n = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe_n, busy, pu_done;
  logic [7:0] status;
  logic [15:0] addr;
  logic [7:0] d0, d1, op;
  int err_total = 0;
  int compares = 0;
  // System clock, 8 ns.
  always #4 i_sys_clk = ~i_sys_clk;
  spi_host_model host (.i_so(so), .i_so_oe_n(so_oe_n), .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n));
  spi_eeprom_command_front_end #(.WRITE_CYCLES(WC), .POWER_UP_CYCLES(16)) DUT (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe_n(so_oe_n), .o_busy(busy),
    .o_status(status), .o_powerup_done(pu_done));
  ////////////////////////////////////////////////////////////////
  // Expected status from guard enable and latch; everything else idle.
  function automatic logic [7:0] stat(input logic g, input logic w);
    return {g, 5'h00, w, 1'b0};
  endfunction
  function automatic bit legal(input logic [7:0] o);
    return o inside {spi_eeprom_pkg::OPC_ENABLE_WRITE, spi_eeprom_pkg::OPC_DISABLE_WRITE,
      spi_eeprom_pkg::OPC_READ_STATUS, spi_eeprom_pkg::OPC_LOAD_STATUS,
      spi_eeprom_pkg::OPC_READ_MEM, spi_eeprom_pkg::OPC_WRITE_MEM};
  endfunction
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // The bound keeps a stuck busy from hanging the run.
  task automatic wait_ready();
    for (int i = 0; i < 4 * WC && busy !== 1'b0; i++) @(posedge i_sys_clk);
    check("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic load(input logic [7:0] v);
    host.run_frame({spi_eeprom_pkg::OPC_ENABLE_WRITE}, 1'b0);
    host.run_frame({spi_eeprom_pkg::OPC_LOAD_STATUS, v}, 1'b0);
    wait_ready();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence; the host waits for power up before any access.
  initial begin
    op = 8'($urandom(3885));
    repeat (6) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    check("reset status", 8'h00, status);
    check("reset oe", 8'h01, {7'h00, so_oe_n});
    for (int i = 0; i < 100 && pu_done !== 1'b1; i++) @(posedge i_sys_clk);
    check("power up", 8'h01, {7'h00, pu_done});
    host.run_frame({spi_eeprom_pkg::OPC_READ_STATUS, 8'h00, 8'h00}, 1'b0);
    check("status out", 8'h00, host.rx_q[2]);
    repeat (4) begin
      do op = 8'($urandom); while (legal(op));
      host.run_frame({op, 8'h00, 8'h00}, 1'b0);
      check("unknown op", 8'h00, status);
    end
    // Even offset keeps both bytes inside one page.
    addr = 16'($urandom) & 16'h1FFE;
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    host.run_frame({spi_eeprom_pkg::OPC_WRITE_MEM, addr[15:8], addr[7:0], d0, d1}, 1'b0);
    check("no latch write", 8'h00, {7'h00, busy});
    host.run_frame({spi_eeprom_pkg::OPC_ENABLE_WRITE}, 1'b0);
    check("latch set", stat(1'b0, 1'b1), status);
    host.run_frame({spi_eeprom_pkg::OPC_DISABLE_WRITE}, 1'b0);
    check("latch clear", stat(1'b0, 1'b0), status);
    host.run_frame({spi_eeprom_pkg::OPC_ENABLE_WRITE}, 1'b0);
    host.run_frame({spi_eeprom_pkg::OPC_WRITE_MEM, addr[15:8], addr[7:0], d0, d1}, 1'b0);
    host.run_frame({spi_eeprom_pkg::OPC_LOAD_STATUS, 8'h80}, 1'b0);
    host.run_frame({spi_eeprom_pkg::OPC_READ_STATUS, 8'h00}, 1'b0);
    check("busy status", 8'h03, host.rx_q[1]);
    wait_ready();
    check("after write", stat(1'b0, 1'b0), status);
    host.run_frame({spi_eeprom_pkg::OPC_READ_MEM, addr[15:8], addr[7:0], 8'h00, 8'h00}, 1'b1);
    check("read byte 0", d0, host.rx_q[3]);
    check("read byte 1", d1, host.rx_q[4]);
    load(8'h80);
    check("guard set", stat(1'b1, 1'b0), status);
    @(posedge i_sys_clk) #1 i_wp_n = 1'b0;
    load(8'h00);
    check("guarded load", 8'h80, status & 8'hFC);
    @(posedge i_sys_clk) #1 i_wp_n = 1'b1;
    load(8'h00);
    check("unguarded load", stat(1'b0, 1'b0), status);
    // Identification page: reached only with page select, frozen once locked.
    load(8'h40);
    host.run_frame({spi_eeprom_pkg::OPC_ENABLE_WRITE}, 1'b0);
    host.run_frame({spi_eeprom_pkg::OPC_WRITE_MEM, addr[15:8], addr[7:0], ~d0}, 1'b0);
    wait_ready();
    check("page select clear", 8'h00, status);
    load(8'h40);
    host.run_frame({spi_eeprom_pkg::OPC_READ_MEM, addr[15:8], addr[7:0], 8'h00}, 1'b0);
    check("id page read", ~d0, host.rx_q[3]);
    host.run_frame({spi_eeprom_pkg::OPC_READ_MEM, addr[15:8], addr[7:0], 8'h00}, 1'b0);
    check("main kept", d0, host.rx_q[3]);
    load(8'h10);
    load(8'h40);
    host.run_frame({spi_eeprom_pkg::OPC_ENABLE_WRITE}, 1'b0);
    host.run_frame({spi_eeprom_pkg::OPC_WRITE_MEM, addr[15:8], addr[7:0], d0}, 1'b0);
    check("locked write", 8'h12, status);
    load(8'h40);
    host.run_frame({spi_eeprom_pkg::OPC_READ_MEM, addr[15:8], addr[7:0], 8'h00}, 1'b0);
    check("locked id read", ~d0, host.rx_q[3]);
    stop_test();
  end
  // Watchdog well past the planned run of about 130 us.
  initial begin
    #500_000;
    err_total++;
    stop_test();
  end
endmodule

// ===== test/spi_host_model.sv
/*
  Host model for the serial link, mode 0, 80 ns clock.
  Assumes one caller at a time; the clock stands low between frames.
*/
`timescale 1ns/100ps
module spi_host_model (
  input wire logic i_so,
  input wire logic i_so_oe_n,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  output logic o_hold_n
);
  logic [7:0] rx_q[$];
  wire so_line;
  // The line floats when the device lets go, so a stale bit cannot pass.
  assign so_line = i_so_oe_n ? 1'bz : i_so;
  // Idle levels at time zero.
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  // One selection; the odd start delay keeps the link off the system clock phase.
  task automatic run_frame(input logic [7:0] tx[$], input bit pause);
    logic [7:0] rx;
    rx_q = {};
    #3.7 o_cs_n = 1'b0;
    #40;
    foreach (tx[i]) begin
      for (int b = 7; b >= 0; b--) begin
        o_si = tx[i][b];
        #40 o_sck = 1'b1;
        rx[b] = so_line;
        #40 o_sck = 1'b0;
      end
      rx_q.push_back(rx);
      if (pause && i == 1) begin
        #10 o_hold_n = 1'b0;
        o_si = ~o_si;
        // Clock pulses during the pause must not move the device.
        repeat (2) begin
          #40 o_sck = 1'b1;
          #40 o_sck = 1'b0;
        end
        #40 o_hold_n = 1'b1;
      end
    end
    #40 o_cs_n = 1'b1;
    o_si = ~o_si;
    #200;
  endtask
endmodule
